// [hw/uefc_top.sv]
// Purpose: usb endpoint fifo control, suspend/resume and usb interrupt
// Assumes: sie delivers token events as one-cycle pulses on clk_i
// Notes:   line and resume pins pass a three-stage synchroniser
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module uefc_top import uefc_pkg::*; #(
    parameter int IDLE_CYCLES = UEFC_IDLE_CYC,
    parameter int EP_DEPTH    = UEFC_EP_DEPTH
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // core interrupt path
    input  wire logic        core_gie_i,
    output logic             usb_int_o,
    // usb line pins
    input  wire logic        usb_line_active_i,
    input  wire logic        usb_resume_i,
    // sie events and data
    input  wire logic        sie_setup_i,
    input  wire logic        sie_zlp_i,
    input  wire logic        sie_bus_reset_i,
    input  wire logic [7:0]  sie_access_i,
    input  wire logic        sie_wr_i,
    input  wire logic        sie_rd_i,
    input  wire logic [2:0]  sie_ep_i,
    input  wire logic [7:0]  sie_wdata_i,
    output logic      [7:0]  sie_rdata_o,
    // configuration to the sie
    output logic      [7:0]  in_pipe_en_o,
    output logic      [7:0]  out_pipe_en_o,
    output logic             first_toggle_o,
    output logic      [2:0]  toggle_ep_o,
    output logic             usb_clk_en_o,
    output logic             suspend_o,
    output logic             current_reduce_o,
    output logic             remote_wake_o,
    output logic             regulator_sel_o
);
    localparam int PW = $clog2(EP_DEPTH);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0]    in_en, out_en, sz_lo, sz_hi, dbuf, uctl, acc, acc_en;
    logic          setup_flag, zlp_flag, req, tx, clr_bit, ready_q;
    logic          resume_flag, wake_bit, wake_q, ien;
    logic [2:0]    line_s, res_s;
    logic          line_q, res_q;
    logic [31:0]   idle_cnt;
    logic [7:0]    cnt  [UEFC_EP_N];
    logic [PW-1:0] wp   [UEFC_EP_N];
    logic [PW-1:0] rp   [UEFC_EP_N];
    logic [7:0]    mem  [UEFC_EP_N*EP_DEPTH];
    logic [7:0]    cap  [UEFC_EP_N];

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire       valid    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire       bwr      = valid & wb_we_i & wb_sel_i[0];
    wire       brd      = valid & ~wb_we_i;
    wire [7:0] wd       = wb_dat_i[7:0];
    wire [2:0] sel      = uctl[2:0];
    wire [7:0] port_adr = UEFC_A_DATA0 + {3'h0, sel, 2'h0};
    wire       at_port  = (wb_adr_i == port_adr);
    wire       wr_hsk   = bwr & (wb_adr_i == UEFC_A_HSK);
    wire       wr_acc   = bwr & (wb_adr_i == UEFC_A_ACC);
    wire       wr_out   = bwr & (wb_adr_i == UEFC_A_OUTEN);
    wire       wr_us    = bwr & (wb_adr_i == UEFC_A_USTAT);

    // pipe enables, endpoint 0 always on
    wire [7:0] out_pipe = out_en & UEFC_OUT_EP_MASK;
    wire [7:0] pipe_en  = {in_en[7:1] | out_pipe[7:1], 1'b1};

    // size code per endpoint, endpoint 0 fixed at the least size
    wire [15:0] codes = {sz_hi, sz_lo[7:2], 2'b00};
    wire [7:0]  dbl   = {4'h0, dbuf[UEFC_DB_EP3], dbuf[UEFC_DB_EP2], 2'b00};
    genvar g;
    generate
        for (g = 0; g < UEFC_EP_N; g++) begin : g_cap
            assign cap[g] = (UEFC_MIN_SIZE << codes[2*g +: 2]) << dbl[g];
        end
    endgenerate

    // fifo ready for the selected endpoint
    wire fifo_room  = tx ? (cnt[sel] < cap[sel]) : (cnt[sel] != 8'h00);
    wire fifo_ready = req & pipe_en[sel] & fifo_room;

    // core and sie side moves
    wire core_wr = bwr & at_port & ready_q & tx;
    wire core_rd = brd & at_port & ready_q & ~tx;
    wire sie_wok = sie_wr_i & ~core_wr & (cnt[sie_ep_i] < cap[sie_ep_i]) & pipe_en[sie_ep_i];
    wire sie_rok = sie_rd_i & (cnt[sie_ep_i] != 8'h00) & pipe_en[sie_ep_i];
    wire clr_pulse = wr_hsk & wd[UEFC_HSK_CLR] & ~clr_bit;

    // memory indices
    wire [2:0]    wep   = core_wr ? sel : sie_ep_i;
    wire [PW-1:0] wptr  = wp[wep];
    wire [7:0]    wbyte = core_wr ? wd : sie_wdata_i;
    wire [7:0]    crd   = mem[{sel, rp[sel]}];
    wire [7:0]    srd   = mem[{sie_ep_i, rp[sie_ep_i]}];

    // per-endpoint push and pop strobes; a pop by both sides at once is not counted
    logic [UEFC_EP_N-1:0] inc_v, rd_v, dec_v;
    generate
        for (g = 0; g < UEFC_EP_N; g++) begin : g_strobe
            assign inc_v[g] = (core_wr & (sel == 3'(g))) | (sie_wok & (sie_ep_i == 3'(g)));
            assign rd_v[g]  = (core_rd & (sel == 3'(g))) | (sie_rok & (sie_ep_i == 3'(g)));
            assign dec_v[g] = rd_v[g] & ~(core_rd & sie_rok & (sel == sie_ep_i));
        end
    endgenerate

    // ----------------------------------------
    // suspend detection and events
    // ----------------------------------------
    wire suspend_flag_enter = ~line_q & ~suspend_o & (idle_cnt == IDLE_CYCLES - 1);
    wire res_set    = suspend_o & res_q & ~resume_flag;
    wire leave      = suspend_o & resume_flag & ~res_q;
    wire acc_rise   = |(sie_access_i & ~acc & pipe_en & acc_en);
    wire ev_any     = suspend_flag_enter | res_set | sie_bus_reset_i | acc_rise;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [7:0] rd_byte;
    wire [7:0] hsk_rd = {zlp_flag, ready_q, setup_flag, regulator_sel_o, 1'b0,
                         clr_bit, tx, req};
    wire [7:0] us_rd  = {4'h0, ien, wake_bit, resume_flag, suspend_o};
    always_comb begin
        if (wb_adr_i == UEFC_A_HSK)        rd_byte = hsk_rd;
        else if (wb_adr_i == UEFC_A_INEN)  rd_byte = in_en;
        else if (wb_adr_i == UEFC_A_OUTEN) rd_byte = out_en;
        else if (wb_adr_i == UEFC_A_SZLO)  rd_byte = sz_lo;
        else if (wb_adr_i == UEFC_A_SZHI)  rd_byte = sz_hi;
        else if (wb_adr_i == UEFC_A_DBUF)  rd_byte = dbuf;
        else if (wb_adr_i == UEFC_A_UCTL)  rd_byte = uctl;
        else if (wb_adr_i == UEFC_A_USTAT) rd_byte = us_rd;
        else if (wb_adr_i == UEFC_A_ACC)   rd_byte = acc;
        else if (wb_adr_i == UEFC_A_ACCEN) rd_byte = acc_en;
        else if (core_rd)                  rd_byte = crd;
        else                               rd_byte = UEFC_RST_BYTE;
    end

    // ----------------------------------------
    // bus answer, one wait state
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= valid;
            wb_dat_o <= brd ? {24'h0, rd_byte} : 32'h0;
        end
    end

    // configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_en  <= UEFC_RST_BYTE;
            out_en <= UEFC_RST_BYTE;
            sz_lo  <= UEFC_RST_BYTE;
            sz_hi  <= UEFC_RST_BYTE;
            dbuf   <= UEFC_RST_BYTE;
            uctl   <= UEFC_RST_BYTE;
            acc_en <= UEFC_RST_BYTE;
        end else begin
            // layout default bit clears itself after one cycle
            if (bwr && wb_adr_i == UEFC_A_INEN) in_en <= wd;
            else                                in_en <= {in_en[7:1], 1'b0};
            if (wr_out)                              out_en <= wd;
            if (bwr && wb_adr_i == UEFC_A_SZLO)  sz_lo  <= wd & UEFC_SZLO_MASK;
            if (bwr && wb_adr_i == UEFC_A_SZHI)  sz_hi  <= wd;
            if (bwr && wb_adr_i == UEFC_A_DBUF)  dbuf   <= wd & UEFC_DBUF_MASK;
            if (bwr && wb_adr_i == UEFC_A_ACCEN) acc_en <= wd;
            if (bwr && wb_adr_i == UEFC_A_UCTL)  uctl   <= wd & UEFC_UCTL_MASK;
            else if (leave)                      uctl[UEFC_UC_SCR] <= 1'b0;
        end
    end

    // handshake bits and flags, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            setup_flag      <= 1'b0;
            zlp_flag        <= 1'b0;
            req             <= 1'b0;
            tx              <= 1'b0;
            clr_bit         <= 1'b0;
            regulator_sel_o <= 1'b0;
            ready_q         <= 1'b0;
            acc             <= UEFC_RST_BYTE;
        end else begin
            ready_q <= fifo_ready;
            if (wr_hsk) begin
                req             <= wd[UEFC_HSK_REQ];
                tx              <= wd[UEFC_HSK_TX];
                clr_bit         <= wd[UEFC_HSK_CLR];
                regulator_sel_o <= wd[UEFC_HSK_REG];
            end
            setup_flag <= sie_setup_i | (setup_flag & ~(wr_hsk & ~wd[UEFC_HSK_SET]));
            zlp_flag   <= sie_zlp_i | (zlp_flag & ~(wr_hsk & ~wd[UEFC_HSK_REQ]));
            acc        <= sie_access_i | (acc & (wr_acc ? wd : 8'hff));
        end
    end

    // ----------------------------------------
    // endpoint fifos
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (core_wr || sie_wok) mem[{wep, wptr}] <= wbyte;
    end

    // per-endpoint counts and pointers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < UEFC_EP_N; i++) begin
                cnt[i] <= 8'h00;
                wp[i]  <= '0;
                rp[i]  <= '0;
            end
        end else begin
            for (int i = 0; i < UEFC_EP_N; i++) begin
                if (clr_pulse && sel == 3'(i)) begin
                    cnt[i] <= 8'h00;
                    wp[i]  <= '0;
                    rp[i]  <= '0;
                end else begin
                    cnt[i] <= cnt[i] + {7'h0, inc_v[i]} - {7'h0, dec_v[i]};
                    if (inc_v[i]) wp[i] <= PW'((wp[i] + 1'b1) & PW'(cap[i] - 8'h01));
                    if (dec_v[i]) rp[i] <= PW'((rp[i] + 1'b1) & PW'(cap[i] - 8'h01));
                end
            end
        end
    end

    // sie read data
    always_ff @(posedge clk_i) begin
        if (rst_i) sie_rdata_o <= UEFC_RST_BYTE;
        else if (sie_rok) sie_rdata_o <= srd;
    end

    // ----------------------------------------
    // line synchronisers and idle timer
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_s <= 3'h0;
            res_s  <= 3'h0;
            line_q <= 1'b0;
            res_q  <= 1'b0;
        end else begin
            line_s <= {line_s[1:0], usb_line_active_i};
            res_s  <= {res_s[1:0], usb_resume_i};
            if (line_s[1] == line_s[2]) line_q <= line_s[2];
            if (res_s[1] == res_s[2])   res_q  <= res_s[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || line_q) idle_cnt <= 32'h0;
        else if (idle_cnt != IDLE_CYCLES) idle_cnt <= idle_cnt + 32'h1;
    end

    // suspend, resume, wake and interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            suspend_o     <= 1'b0;
            resume_flag   <= 1'b0;
            wake_bit      <= 1'b0;
            wake_q        <= 1'b0;
            ien           <= 1'b0;
            remote_wake_o <= 1'b0;
            usb_int_o     <= 1'b0;
        end else begin
            if (suspend_flag_enter)  suspend_o <= 1'b1;
            else if (leave)  suspend_o <= 1'b0;
            if (res_set)     resume_flag <= 1'b1;
            else if (leave)  resume_flag <= 1'b0;
            if (wr_us) begin
                wake_bit <= wd[UEFC_US_WAKE];
                ien      <= wd[UEFC_US_IEN];
            end
            wake_q        <= wake_bit;
            remote_wake_o <= wake_bit & ~wake_q;
            usb_int_o     <= ev_any & ien & core_gie_i;
        end
    end

    // mirrored configuration
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_pipe_en_o     <= UEFC_RST_BYTE;
            out_pipe_en_o    <= UEFC_RST_BYTE;
            first_toggle_o   <= 1'b0;
            toggle_ep_o      <= 3'h0;
            usb_clk_en_o     <= 1'b0;
            current_reduce_o <= 1'b0;
        end else begin
            in_pipe_en_o     <= {in_en[7:1], 1'b0};
            out_pipe_en_o    <= out_pipe;
            first_toggle_o   <= out_en[UEFC_OUT_TOG];
            toggle_ep_o      <= sel;
            usb_clk_en_o     <= uctl[UEFC_UC_CKEN];
            current_reduce_o <= uctl[UEFC_UC_SCR];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_suspend_flag_cause;
        suspend_flag_enter && ien && core_gie_i;
    endsequence

    setup_flag_set_a: assert property (sie_setup_i |=> setup_flag)
        else $error("setup flag not set");
    fifo_clear_empty_a: assert property (clr_pulse |=> cnt[$past(sel)] == 8'h00)
        else $error("fifo not empty after clear");
    in_en_reset_a: assert property ($past(rst_i) |-> in_en == 8'h00)
        else $error("in enables not reset");
    out_en_reset_a: assert property ($past(rst_i) |-> out_en == 8'h00)
        else $error("out enables not reset");
    toggle_load_a: assert property (wr_out |=> ##1
        first_toggle_o == $past(wd[UEFC_OUT_TOG], 2))
        else $error("toggle select not loaded");
    count_cap_a: assert property (cnt[sel] <= cap[sel])
        else $error("fifo count above size");
    suspend_int_a: assert property (s_suspend_flag_cause |=> usb_int_o && suspend_o)
        else $error("suspend without interrupt");
    int_cause_a: assert property (usb_int_o |-> $past(ev_any && ien && core_gie_i))
        else $error("interrupt without enabled cause");
    leave_clears_a: assert property (leave |=> !resume_flag ##1 !current_reduce_o)
        else $error("suspend exit left flags");
    wake_pulse_a: assert property (remote_wake_o |=> !remote_wake_o)
        else $error("wake pulse too long");
    ready_req_a: assert property (ready_q |-> $past(req))
        else $error("ready without request");
    access_set_a: assert property (sie_access_i[sel] |=> acc[$past(sel)])
        else $error("access flag not set");
endmodule

// [hw/uefc_pkg.sv]
// Purpose: constants for the usb endpoint fifo control block
// Assumes: classic wishbone slave, 32-bit data, registers in the low byte
// Notes:   one word per register, byte addresses below
//
// Functional notes
// - setup packet sets flag; only software clears
// - after clear, endpoint fifo accepts/sends new data
// - endpoints 1-7 in pipe enables, reset 0
// - out enables for endpoints 1,4,5,6,7, reset 0
// - toggle bit picks DATA0 or DATA1 first
// - two-bit size code: 8,16,32,64 bytes
// - endpoints 2,3 in double buffer select bits
// - one byte data port per endpoint
// - idle over 3ms: suspend, flag, interrupt
// - host resume sets resume flag, interrupts core
// - leaving suspend clears current reduce and resume
// - wake bit high sends remote wake pulse
// - interrupt on suspend, resume, reset, fifo access
// - access interrupt needs pipe and interrupt enable
// - suspend/resume interrupt direct; flags read only
// - interrupt needs module, global, usb enables; code gates usb_int_o with ien and core_gie_i
// - three-bit select picks endpoint 0 to 7
// - host access sets endpoint access flag
package uefc_pkg;
    // ----------------------------------------
    // register byte addresses
    // ----------------------------------------
    localparam logic [7:0] UEFC_A_HSK   = 8'h00;
    localparam logic [7:0] UEFC_A_INEN  = 8'h04;
    localparam logic [7:0] UEFC_A_OUTEN = 8'h08;
    localparam logic [7:0] UEFC_A_SZLO  = 8'h0c;
    localparam logic [7:0] UEFC_A_SZHI  = 8'h10;
    localparam logic [7:0] UEFC_A_DBUF  = 8'h14;
    localparam logic [7:0] UEFC_A_UCTL  = 8'h18;
    localparam logic [7:0] UEFC_A_USTAT = 8'h1c;
    localparam logic [7:0] UEFC_A_ACC   = 8'h20;
    localparam logic [7:0] UEFC_A_ACCEN = 8'h24;
    localparam logic [7:0] UEFC_A_DATA0 = 8'h28;
    localparam logic [7:0] UEFC_A_STEP  = 8'h04;
    // ----------------------------------------
    // field positions and masks
    // ----------------------------------------
    localparam int UEFC_HSK_ZLP = 7;
    localparam int UEFC_HSK_RDY = 6;
    localparam int UEFC_HSK_SET = 5;
    localparam int UEFC_HSK_REG = 4;
    localparam int UEFC_HSK_CLR = 2;
    localparam int UEFC_HSK_TX  = 1;
    localparam int UEFC_HSK_REQ = 0;
    localparam int UEFC_OUT_TOG = 0;
    localparam int UEFC_UC_SCR  = 4;
    localparam int UEFC_UC_CKEN = 3;
    localparam int UEFC_US_SUSPEND_FLAG = 0;
    localparam int UEFC_US_RES  = 1;
    localparam int UEFC_US_WAKE = 2;
    localparam int UEFC_US_IEN  = 3;
    localparam int UEFC_DB_EP2  = 0;
    localparam int UEFC_DB_EP3  = 2;
    localparam logic [7:0] UEFC_OUT_EP_MASK = 8'hf2;
    localparam logic [7:0] UEFC_SZLO_MASK   = 8'hfc;
    localparam logic [7:0] UEFC_DBUF_MASK   = 8'h0f;
    localparam logic [7:0] UEFC_UCTL_MASK   = 8'h1f;
    localparam logic [7:0] UEFC_RST_BYTE    = 8'h00;
    // ----------------------------------------
    // sizes and timing
    // ----------------------------------------
    localparam int         UEFC_EP_N     = 8;
    localparam int         UEFC_EP_DEPTH = 128;
    localparam logic [7:0] UEFC_MIN_SIZE = 8'h08;
    localparam int         UEFC_CLK_HZ   = 40000000;
    localparam int         UEFC_IDLE_MS  = 3;
    localparam int         UEFC_IDLE_CYC = UEFC_IDLE_MS * (UEFC_CLK_HZ / 1000);
endpackage

// [verif/uefc_host_model.sv]
// Purpose: host and sie side model for the endpoint fifo block
// Assumes: one clock, sie events are one-cycle pulses
// Notes:   answers a remote wake pulse with resume signalling
`timescale 1ns/1ps
module uefc_host_model (
    // clock and device side
    input  wire logic       clk_i,
    input  wire logic       remote_wake_i,
    input  wire logic [7:0] rdata_i,
    // pins and sie events
    output logic            line_o,
    output logic            resume_o,
    output logic            setup_o,
    output logic            bus_reset_o,
    output logic      [7:0] access_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [2:0] ep_o,
    output logic      [7:0] wdata_o
);
    // bus active, no events at start
    initial begin
        {line_o, resume_o, setup_o, bus_reset_o, access_o} = 12'h800;
        {wr_o, rd_o, ep_o, wdata_o} = 13'h0000;
    end
    // one-cycle event pulse
    task evt(input logic s, input logic r, input logic [7:0] a);
        @(posedge clk_i);
        {setup_o, bus_reset_o, access_o} <= {s, r, a};
        @(posedge clk_i);
        {setup_o, bus_reset_o, access_o} <= 10'h000;
    endtask
    // host sends one byte into a fifo
    task put(input logic [2:0] e, input logic [7:0] b);
        @(posedge clk_i);
        {wr_o, ep_o, wdata_o} <= {1'b1, e, b};
        @(posedge clk_i);
        {wr_o, wdata_o} <= {1'b0, ~b};  // stale data inverted
    endtask
    // host takes one byte from a fifo
    task get(input logic [2:0] e, output logic [7:0] b);
        @(posedge clk_i);
        {rd_o, ep_o} <= {1'b1, e};
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        b = rdata_i;
    endtask
    // bus goes quiet
    task idle;
        @(posedge clk_i);
        line_o <= 1'b0;
    endtask
    // resume in answer to wake, then traffic again
    always @(posedge clk_i) begin
        if (remote_wake_i === 1'b1) begin
            repeat (8) @(posedge clk_i);
            resume_o <= 1'b1;
            repeat (12) @(posedge clk_i);
            resume_o <= 1'b0;
            line_o   <= 1'b1;
        end
    end
endmodule

// [verif/testbench.sv]
// Purpose: self-checking bench for the endpoint fifo control block
// Assumes: wishbone answers after one wait state
// Notes:   idle count shortened to 50 cycles
`timescale 1ns/1ps
module testbench;
    import uefc_pkg::*;
    localparam int IDLE = 50;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_wdat = 32'h0;
    logic        gie = 1'b0;
    logic [31:0] wb_rdat;
    logic        wb_ack, usb_int, line, resume, setup, bus_rst, sie_wr, sie_rd;
    logic [7:0]  access, wdata, rdata, in_en, out_en, q;
    logic [2:0]  ep, tog_ep;
    logic        tog, clk_en, suspend_flag, cred, wake, reg_sel;
    int          error_cnt = 0;
    int          checks_done = 0;
    int          int_cnt = 0;
    int          wake_cnt = 0;
    int          n0;
    int          n;

    uefc_top #(.IDLE_CYCLES(IDLE)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .core_gie_i(gie), .usb_int_o(usb_int),
        .usb_line_active_i(line), .usb_resume_i(resume), .sie_setup_i(setup),
        .sie_zlp_i(1'b0), .sie_bus_reset_i(bus_rst), .sie_access_i(access),
        .sie_wr_i(sie_wr), .sie_rd_i(sie_rd), .sie_ep_i(ep), .sie_wdata_i(wdata),
        .sie_rdata_o(rdata), .in_pipe_en_o(in_en), .out_pipe_en_o(out_en),
        .first_toggle_o(tog), .toggle_ep_o(tog_ep), .usb_clk_en_o(clk_en), .suspend_o(suspend_flag),
        .current_reduce_o(cred), .remote_wake_o(wake), .regulator_sel_o(reg_sel)
    );
    uefc_host_model host_u (
        .clk_i(clk_i), .remote_wake_i(wake), .rdata_i(rdata), .line_o(line),
        .resume_o(resume), .setup_o(setup), .bus_reset_o(bus_rst), .access_o(access),
        .wr_o(sie_wr), .rd_o(sie_rd), .ep_o(ep), .wdata_o(wdata)
    );

    // clock and pulse counters
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (usb_int === 1'b1) int_cnt++;
        if (wake === 1'b1) wake_cnt++;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
        end
    endtask
    task bound(input int k);
        if (k >= 60) begin
            error_cnt++;
            give_verdict();
        end
    endtask
    // one classic wishbone cycle
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        int k;
        @(posedge clk_i);
        {wb_cyc, wb_we, wb_adr, wb_wdat} <= {1'b1, w, a, 24'h0, d};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack !== 1'b1 && k < 60);
        bound(k);
        r = wb_rdat[7:0];
        wb_cyc <= 1'b0;
    endtask
    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask
    task reg_chk(input logic [7:0] a, input logic [7:0] e, input string s);
        logic [7:0] r;
        wb(1'b0, a, 8'h00, r);
        check(r, e, s);
    endtask
    // poll fifo ready
    task wait_ready;
        int k;
        k = 0;
        do begin
            wb(1'b0, UEFC_A_HSK, 8'h00, q);
            k++;
        end while (q[UEFC_HSK_RDY] !== 1'b1 && k < 60);
        bound(k);
    endtask

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values and storage
        reg_chk(UEFC_A_INEN, 8'h00, "in enable reset");
        reg_chk(UEFC_A_OUTEN, 8'h00, "out enable reset");
        reg_chk(UEFC_A_SZLO, 8'h00, "size low reset");
        reg_wr(UEFC_A_INEN, 8'hfe);
        reg_wr(UEFC_A_OUTEN, 8'hf3);
        reg_wr(UEFC_A_SZLO, 8'hff);
        reg_wr(UEFC_A_SZHI, 8'he4);
        reg_wr(UEFC_A_DBUF, 8'h05);
        check(in_en, 8'hfe, "in pipes");
        check(out_en, 8'hf2, "out pipes");
        check({7'h0, tog}, 8'h01, "toggle one");
        reg_chk(UEFC_A_SZLO, 8'hfc, "size low");
        reg_chk(UEFC_A_SZHI, 8'he4, "size high");
        reg_chk(UEFC_A_DBUF, 8'h05, "dbuf");
        reg_chk(8'hfc, 8'h00, "unmapped");
        $display("test registers done");
        // host out data read by core on ep1
        reg_wr(UEFC_A_UCTL, 8'h09);
        for (int i = 0; i < 2; i++) host_u.put(3'd1, 8'h5a + 8'(i));
        reg_wr(UEFC_A_HSK, 8'h01);
        wait_ready();
        for (int i = 0; i < 2; i++) reg_chk(8'h2c, 8'h5a + 8'(i), "out byte");
        reg_wr(UEFC_A_HSK, 8'h03);
        reg_wr(UEFC_A_HSK, 8'h02);
        $display("test core read done");
        // core write on ep2, host takes it
        reg_wr(UEFC_A_UCTL, 8'h0a);
        reg_wr(UEFC_A_HSK, 8'h03);
        wait_ready();
        for (int i = 0; i < 3; i++) reg_wr(8'h30, 8'ha0 + 8'(i));
        reg_wr(UEFC_A_HSK, 8'h01);
        reg_wr(UEFC_A_HSK, 8'h00);
        for (int i = 0; i < 3; i++) begin
            host_u.get(3'd2, q);
            check(q, 8'ha0 + 8'(i), "in byte");
        end
        $display("test core write done");
        // clear drops stale byte
        reg_wr(UEFC_A_UCTL, 8'h09);
        host_u.put(3'd1, 8'h11);
        reg_wr(UEFC_A_HSK, 8'h01);
        reg_wr(UEFC_A_HSK, 8'h05);
        reg_wr(UEFC_A_HSK, 8'h01);
        host_u.put(3'd1, 8'h22);
        wait_ready();
        reg_chk(8'h2c, 8'h22, "after clear");
        reg_wr(UEFC_A_HSK, 8'h03);
        reg_wr(UEFC_A_HSK, 8'h02);
        // setup flag kept until written 0
        host_u.evt(1'b1, 1'b0, 8'h00);
        reg_wr(UEFC_A_HSK, 8'h30);
        wb(1'b0, UEFC_A_HSK, 8'h00, q);
        check({7'h0, q[UEFC_HSK_SET]}, 8'h01, "setup set");
        check({7'h0, reg_sel}, 8'h01, "regulator select");
        reg_wr(UEFC_A_HSK, 8'h00);
        wb(1'b0, UEFC_A_HSK, 8'h00, q);
        check({7'h0, q[UEFC_HSK_SET]}, 8'h00, "setup clear");
        $display("test clear and setup done");
        // interrupt sources and gating
        reg_wr(UEFC_A_USTAT, 8'h08);
        reg_wr(UEFC_A_ACCEN, 8'h02);
        gie <= 1'b1;
        n0 = int_cnt;
        host_u.evt(1'b0, 1'b0, 8'h02);
        host_u.evt(1'b0, 1'b0, 8'h08);
        host_u.evt(1'b0, 1'b1, 8'h00);
        repeat (3) @(posedge clk_i);
        check(8'(int_cnt - n0), 8'h02, "events");
        reg_chk(UEFC_A_ACC, 8'h0a, "access flags");
        reg_wr(UEFC_A_ACC, 8'hf5);
        reg_chk(UEFC_A_ACC, 8'h00, "flags cleared");
        gie <= 1'b0;
        n0 = int_cnt;
        host_u.evt(1'b0, 1'b0, 8'h02);
        repeat (3) @(posedge clk_i);
        check(8'(int_cnt - n0), 8'h00, "gated");
        reg_wr(UEFC_A_ACC, 8'h00);
        gie <= 1'b1;
        $display("test interrupts done");
        // suspend, remote wake, resume
        n0 = int_cnt;
        host_u.idle();
        repeat (IDLE - 5) @(posedge clk_i);
        check({7'h0, suspend_flag}, 8'h00, "early suspend");
        n = 0;
        while (suspend_flag !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        bound(n);
        repeat (2) @(posedge clk_i);
        check(8'(int_cnt - n0), 8'h01, "suspend int");
        reg_chk(UEFC_A_USTAT, 8'h09, "suspend flag");
        reg_wr(UEFC_A_UCTL, 8'h11);
        @(posedge clk_i);
        check({6'h0, clk_en, cred}, 8'h01, "low power");
        check({5'h0, tog_ep}, 8'h01, "toggle endpoint");
        reg_wr(UEFC_A_USTAT, 8'h0c);
        reg_chk(UEFC_A_USTAT, 8'h0d, "read only flags");
        check(8'(wake_cnt), 8'h01, "wake pulse");
        n = 0;
        while (suspend_flag !== 1'b0 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        bound(n);
        repeat (2) @(posedge clk_i);
        check(8'(int_cnt - n0), 8'h02, "resume int");
        check({7'h0, cred}, 8'h00, "reduce cleared");
        reg_chk(UEFC_A_USTAT, 8'h0c, "resume cleared");
        $display("test suspend done");
        give_verdict();
    end
endmodule
